// ---- design/sws_top.sv ----
`timescale 1ns/1ps
`include "sws_map.svh"
module sws_top #(
	parameter int OSC_CYCLES     = `SWS_OSC_CYCLES,     // system clocks per oscillator period
	parameter int WD_DIV_NORM    = `SWS_WD_DIV_NORM,    // oscillator periods per tick
	parameter int WD_DIV_FAST    = `SWS_WD_DIV_FAST,    // same in fast test modes
	parameter int SAFE_DELAY_OSC = `SWS_SAFE_DELAY_OSC  // safing hold in oscillator periods
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic ce_i,
	input  wire logic logic_supply_good_i,
	input  wire logic high_voltage_rail_ok_i,
	input  wire logic test_select_pin_high_i,
	input  wire logic test_select_pin_over_i,
	input  wire logic lamp_polarity_strap_i,
	input  wire logic lamp_enable_in_i,
	input  wire logic safing_input_hold_i,
	input  wire logic mode_pin_i,
	input  wire logic serial_shift_clock_i,
	input  wire logic serial_data_i,
	input  wire logic select_low_in_i,
	input  wire logic firing_enable_in_i,
	output logic      host_reset_low_out_o,
	output logic      firing_enable_out_o,
	output logic      firing_enable_oe_o,
	output logic      firing_allowed_o,
	output logic      warning_lamp_driver_o,
	output logic      extended_mode_o,
	output logic      trigger_window_o
);
	localparam int OW = $clog2(OSC_CYCLES + 1);
	localparam int SW = $clog2(SAFE_DELAY_OSC + 1);

	// ==================== input synchronisers
	logic [7:0] async_in;  // raw comparator and strap levels
	logic [7:0] sync1_r;   // first stage, read only by second
	logic [7:0] sync2_r;   // usable levels
	logic       supply_ok_s;
	logic       hv_ok_s;
	logic       tp_high_s;
	logic       tp_over_s;
	logic       strap_open_s;
	logic       lamp_en_s;
	logic       safing_s;
	logic       mode_pin_s;

	assign async_in = {mode_pin_i, safing_input_hold_i, lamp_enable_in_i,
		lamp_polarity_strap_i, test_select_pin_over_i, test_select_pin_high_i,
		high_voltage_rail_ok_i, logic_supply_good_i};

	// two flops per comparator line
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_sync
			always_ff @(posedge clk_i or posedge rst_i) begin
				if (rst_i) begin
					sync1_r[gi] <= 1'b0;
					sync2_r[gi] <= 1'b0;
				end else if (ce_i) begin
					sync1_r[gi] <= async_in[gi];
					sync2_r[gi] <= sync1_r[gi];
				end
			end
		end
	endgenerate

	assign supply_ok_s  = sync2_r[0];
	assign hv_ok_s      = sync2_r[1];
	assign tp_high_s    = sync2_r[2];
	assign tp_over_s    = sync2_r[3];
	assign strap_open_s = sync2_r[4];
	assign lamp_en_s    = sync2_r[5];
	assign safing_s     = sync2_r[6];
	assign mode_pin_s   = sync2_r[7];

	// ==================== test mode decode
	logic forced_high; // modes A and C: outputs pinned high
	logic fast_tick;   // modes B and C: divide by 4 instead of 100

	assign forced_high = (tp_high_s | tp_over_s) & strap_open_s;
	assign fast_tick   = tp_over_s | (tp_high_s & ~strap_open_s);

	// ==================== serial command receiver
	sws_cmd_if cmd_bus ();

	sws_spi_rx u_rx (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.ce_i      (ce_i),
		.sclk_i    (serial_shift_clock_i),
		.sdi_i     (serial_data_i),
		.sel_low_i (select_low_in_i),
		.cmd       (cmd_bus.src)
	);

	// word to command class
	function automatic sws_pkg::sws_cmd_t cmd_decode(input logic [15:0] w);
		sws_pkg::sws_cmd_t c;
		c = sws_pkg::CMD_NONE;
		if (w == `SWS_CMD_SOFT_RST) begin
			c = sws_pkg::CMD_SOFT_RST;
		end else if (w[15:8] == `SWS_CMD_MODE_HI) begin
			c = sws_pkg::CMD_MODE;
		end else if (w == `SWS_CMD_TRIG_SET) begin
			c = sws_pkg::CMD_TRIG_SET;
		end else if (w == `SWS_CMD_TRIG_CLR) begin
			c = sws_pkg::CMD_TRIG_CLR;
		end else if (w == `SWS_CMD_LAMP_DEF) begin
			c = sws_pkg::CMD_LAMP_DEF;
		end else if (w == `SWS_CMD_LAMP_INV) begin
			c = sws_pkg::CMD_LAMP_INV;
		end
		return c;
	endfunction

	sws_pkg::sws_cmd_t cmd;     // class of the latched word
	logic              cmd_ok;  // command allowed to act
	logic              ext_mode_r;

	assign cmd = cmd_bus.valid ? cmd_decode(cmd_bus.word) : sws_pkg::CMD_NONE;
	// with the pin high nothing but the mode command is honoured until it arrives
	assign cmd_ok = ~mode_pin_s | ext_mode_r;

	// ==================== oscillator and watchdog tick
	logic [OW-1:0] osc_cnt_r; // system clocks within one oscillator period
	logic [6:0]    wd_cnt_r;  // oscillator periods within one tick
	logic          osc_tick;
	logic          wd_tick;
	logic [6:0]    wd_div_m1;

	assign osc_tick  = osc_cnt_r == OW'(OSC_CYCLES - 1);
	assign wd_div_m1 = fast_tick ? 7'(WD_DIV_FAST - 1) : 7'(WD_DIV_NORM - 1);
	assign wd_tick   = osc_tick & (wd_cnt_r >= wd_div_m1);

	// oscillator period emulation
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			osc_cnt_r <= '0;
		end else if (ce_i) begin
			osc_cnt_r <= osc_tick ? '0 : osc_cnt_r + OW'(1);
		end
	end

	// divide oscillator down to the watchdog clock
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wd_cnt_r <= 7'h00;
		end else if (ce_i && osc_tick) begin
			wd_cnt_r <= wd_tick ? 7'h00 : wd_cnt_r + 7'h01;
		end
	end

	// ==================== power-down detection
	logic [11:0] pd_cnt_r;  // how long the supply has been low
	logic        power_down_r;

	// short dips under the filter time are ignored, longer ones reset
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pd_cnt_r     <= 12'h000;
			power_down_r <= 1'b1;
		end else if (ce_i) begin
			if (supply_ok_s) begin
				pd_cnt_r     <= 12'h000;
				power_down_r <= 1'b0;
			end else if (pd_cnt_r == 12'(`SWS_PD_CYCLES - 1)) begin
				power_down_r <= 1'b1;
			end else begin
				pd_cnt_r <= pd_cnt_r + 12'h001;
			end
		end
	end

	// ==================== trigger latch and sampler
	logic       trig_r;    // trigger pulse set by command
	logic [1:0] hi_cnt_r;  // high samples, saturates at 2
	logic       lo_one_r;  // first low sample taken
	logic       trig_evt;  // second low sample after a pulse
	logic       trig_len_ok;

	// set and hold until cleared; other commands still processed
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			trig_r <= 1'b0;
		end else if (ce_i) begin
			if (power_down_r) begin
				trig_r <= 1'b0;
			end else if (cmd_ok && cmd == sws_pkg::CMD_TRIG_SET) begin
				trig_r <= 1'b1;
			end else if (cmd_ok && (cmd == sws_pkg::CMD_TRIG_CLR ||
					cmd == sws_pkg::CMD_SOFT_RST)) begin
				trig_r <= 1'b0;
			end
		end
	end

	assign trig_evt    = wd_tick & ~trig_r & (hi_cnt_r != 2'b00) & lo_one_r;
	assign trig_len_ok = hi_cnt_r == 2'(`SWS_MIN_SAMPLES);

	// count samples only on watchdog ticks
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			hi_cnt_r <= 2'b00;
			lo_one_r <= 1'b0;
		end else if (ce_i) begin
			if (power_down_r) begin
				hi_cnt_r <= 2'b00;
				lo_one_r <= 1'b0;
			end else if (wd_tick) begin
				if (trig_r) begin
					if (hi_cnt_r != 2'b10) begin
						hi_cnt_r <= hi_cnt_r + 2'b01;
					end
					lo_one_r <= 1'b0;
				end else if (trig_evt) begin
					hi_cnt_r <= 2'b00;
					lo_one_r <= 1'b0;
				end else if (hi_cnt_r != 2'b00) begin
					lo_one_r <= 1'b1;
				end
			end
		end
	end

	// ==================== watchdog state machine
	sws_pkg::sws_state_t state_r;
	sws_pkg::sws_state_t state_nxt;
	logic [6:0]          tcnt_r;   // ticks spent in the state
	logic [6:0]          tcnt_nxt;
	logic                good_trig;
	logic                bad_trig;
	logic                win_miss;

	assign good_trig = trig_evt & trig_len_ok & (state_r == sws_pkg::ST_WIN);
	// early pulse, or a pulse of wrong length inside the window
	assign bad_trig = trig_evt & ((state_r == sws_pkg::ST_WAIT) |
		((state_r == sws_pkg::ST_WIN) & ~trig_len_ok));
	assign win_miss = wd_tick & (state_r == sws_pkg::ST_WIN) &
		(tcnt_r == 7'(`SWS_WIN_LEN_TICKS - 1));

	// next state; power-down beats everything
	always_comb begin
		state_nxt = state_r;
		tcnt_nxt  = wd_tick ? tcnt_r + 7'h01 : tcnt_r;
		case (state_r)
			sws_pkg::ST_POR: begin
				if (power_down_r) begin
					tcnt_nxt = 7'h00;
				end else if (wd_tick && tcnt_r == 7'(`SWS_POR_TICKS - 1)) begin
					state_nxt = sws_pkg::ST_WAIT;
					tcnt_nxt  = 7'h00;
				end
			end
			sws_pkg::ST_WAIT: begin
				if (bad_trig) begin
					state_nxt = sws_pkg::ST_FAULT;
					tcnt_nxt  = 7'h00;
				end else if (wd_tick && tcnt_r == 7'(`SWS_WIN_OPEN_TICKS - 1)) begin
					state_nxt = sws_pkg::ST_WIN;
					tcnt_nxt  = 7'h00;
				end
			end
			sws_pkg::ST_WIN: begin
				if (good_trig) begin
					state_nxt = sws_pkg::ST_WAIT;
					tcnt_nxt  = 7'h00;
				end else if (bad_trig || win_miss) begin
					state_nxt = sws_pkg::ST_FAULT;
					tcnt_nxt  = 7'h00;
				end
			end
			sws_pkg::ST_FAULT: begin
				if (wd_tick && tcnt_r == 7'(`SWS_FAULT_TICKS - 1)) begin
					state_nxt = sws_pkg::ST_RST;
					tcnt_nxt  = 7'h00;
				end
			end
			sws_pkg::ST_RST: begin
				if (wd_tick && tcnt_r == 7'(`SWS_RST_TICKS - 1)) begin
					state_nxt = sws_pkg::ST_WAIT;
					tcnt_nxt  = 7'h00;
				end
			end
			default: begin
				state_nxt = sws_pkg::ST_POR;
				tcnt_nxt  = 7'h00;
			end
		endcase
		if (power_down_r) begin
			state_nxt = sws_pkg::ST_POR;
			tcnt_nxt  = 7'h00;
		end
	end

	// state register
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_r <= sws_pkg::ST_POR;
			tcnt_r  <= 7'h00;
		end else if (ce_i) begin
			state_r <= state_nxt;
			tcnt_r  <= tcnt_nxt;
		end
	end

	logic rst_high;  // host reset released by the watchdog
	logic rst_rise;  // release happens this cycle

	assign rst_high = (state_r == sws_pkg::ST_WAIT) | (state_r == sws_pkg::ST_WIN) |
		(state_r == sws_pkg::ST_FAULT);
	assign rst_rise = (state_nxt == sws_pkg::ST_WAIT) &
		((state_r == sws_pkg::ST_POR) | (state_r == sws_pkg::ST_RST));

	// ==================== safing delay after reset release
	logic          safe_hold_r;  // first enable held back
	logic [SW-1:0] safe_cnt_r;   // oscillator periods since release

	// condition captured at every release, then times out once
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			safe_hold_r <= 1'b0;
			safe_cnt_r  <= '0;
		end else if (ce_i) begin
			if (rst_rise) begin
				safe_hold_r <= safing_s;
				safe_cnt_r  <= '0;
			end else if (!rst_high) begin
				safe_hold_r <= 1'b0;
			end else if (safe_hold_r && osc_tick) begin
				if (safe_cnt_r == SW'(SAFE_DELAY_OSC - 1)) begin
					safe_hold_r <= 1'b0;
				end else begin
					safe_cnt_r <= safe_cnt_r + SW'(1);
				end
			end
		end
	end

	// ==================== firing enable
	logic fe_r;       // internal enable level
	logic fe_pend_r;  // good trigger waiting for safing delay
	logic fe_kill;

	assign fe_kill = bad_trig | win_miss | ~rst_high | power_down_r;

	// clear beats set: a fault in the same cycle wins
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			fe_r      <= 1'b0;
			fe_pend_r <= 1'b0;
		end else if (ce_i) begin
			if (fe_kill) begin
				fe_r      <= 1'b0;
				fe_pend_r <= 1'b0;
			end else if (good_trig && safe_hold_r) begin
				fe_pend_r <= 1'b1;
			end else if (good_trig || (fe_pend_r && !safe_hold_r)) begin
				fe_r      <= 1'b1;
				fe_pend_r <= 1'b0;
			end
		end
	end

	// ==================== mode selection
	// soft reset leaves the mode alone; a host reset or a low mode pin drops it
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ext_mode_r <= 1'b0;
		end else if (ce_i) begin
			if (!rst_high || !mode_pin_s) begin
				ext_mode_r <= 1'b0;
			end else if (cmd == sws_pkg::CMD_MODE) begin
				ext_mode_r <= 1'b1;
			end
		end
	end

	// ==================== warning lamp
	logic lamp_inv_r; // inverse of strap default selected
	logic lamp_live;  // commands may steer the lamp

	assign lamp_live = rst_high & lamp_en_s & hv_ok_s & ~power_down_r;

	// selection falls back to default whenever the lamp is not live
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			lamp_inv_r <= 1'b0;
		end else if (ce_i) begin
			if (!lamp_live) begin
				lamp_inv_r <= 1'b0;
			end else if (cmd_ok && cmd == sws_pkg::CMD_LAMP_INV) begin
				lamp_inv_r <= 1'b1;
			end else if (cmd_ok && (cmd == sws_pkg::CMD_LAMP_DEF ||
					cmd == sws_pkg::CMD_SOFT_RST)) begin
				lamp_inv_r <= 1'b0;
			end
		end
	end

	// ==================== output registers
	logic fe_level; // level the enable pin is to show

	assign fe_level = ~power_down_r & (forced_high | fe_r);

	// every pin comes straight from a flop
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			host_reset_low_out_o  <= 1'b0;
			firing_enable_out_o   <= 1'b0;
			firing_enable_oe_o    <= 1'b1;
			firing_allowed_o      <= 1'b0;
			warning_lamp_driver_o <= 1'b0;
			extended_mode_o       <= 1'b0;
			trigger_window_o      <= 1'b0;
		end else if (ce_i) begin
			host_reset_low_out_o  <= ~power_down_r & (forced_high | rst_high);
			firing_enable_out_o   <= 1'b0; // open drain only pulls low
			firing_enable_oe_o    <= ~fe_level;
			// an outside party holding the line low blocks firing
			firing_allowed_o      <= fe_level & firing_enable_in_i;
			warning_lamp_driver_o <= strap_open_s ^ (lamp_live & lamp_inv_r);
			extended_mode_o       <= ext_mode_r;
			trigger_window_o      <= state_r == sws_pkg::ST_WIN;
		end
	end
endmodule

// ---- design/sws_map.svh ----
`ifndef SWS_MAP_SVH
`define SWS_MAP_SVH
// How it works
// - reset low until supply good plus 64 ms
// - supply drop asserts reset within 10-150 us
// - watchdog tick is oscillator divided by 100
// - power-on reset low phase lasts 64 ticks
// - window opens 32 ticks after release, 32 long
// - good trigger or power-down restarts window sequence
// - bad trigger: reset after 64, held 64 ticks
// - second low sample inside window means good if two high samples came first
// - trigger set/clear commands latch the trigger
// - firing enable rises on first valid trigger
// - firing enable drops at once on any fault
// - firing enable open drain, external low blocks
// - test modes A, B, C from pin and strap
// - safing condition delays first enable 9800 oscillator periods
// - sixteen-bit shift register, latch and decoder
// - shift data into bit zero on clock rise
// - latch only after exactly sixteen clocks, select rise
// - extended mode needs pin high plus mode command
// - basic mode default, host reset returns to it
// - lamp default from strap unless fully enabled
// - lamp commands pick strap default or inverse
// - soft reset keeps the selected operating mode

// ==================== timing
`define SWS_CLK_PERIOD_NS   5
`define SWS_OSC_PERIOD_NS   10000
`define SWS_OSC_CYCLES      (`SWS_OSC_PERIOD_NS / `SWS_CLK_PERIOD_NS)
`define SWS_WD_DIV_NORM     100
`define SWS_WD_DIV_FAST     4
`define SWS_POR_HOLD_MS     64
`define SWS_WD_FREQ_KHZ     1
`define SWS_POR_TICKS       (`SWS_POR_HOLD_MS * `SWS_WD_FREQ_KHZ)
`define SWS_WIN_OPEN_TICKS  32
`define SWS_WIN_LEN_TICKS   32
`define SWS_FAULT_TICKS     64
`define SWS_RST_TICKS       64
`define SWS_MIN_SAMPLES     2
`define SWS_PD_DELAY_US     10
`define SWS_PD_CYCLES       \
	((`SWS_PD_DELAY_US * 1000 + `SWS_CLK_PERIOD_NS - 1) / `SWS_CLK_PERIOD_NS)
`define SWS_SAFE_DELAY_OSC  9800

// ==================== serial frame and commands
`define SWS_FRAME_BITS      16
`define SWS_CMD_MODE_HI     8'hFE
`define SWS_CMD_SOFT_RST    16'hFFFF
`define SWS_CMD_TRIG_SET    16'h0A01
`define SWS_CMD_TRIG_CLR    16'h0A00
`define SWS_CMD_LAMP_DEF    16'h0B00
`define SWS_CMD_LAMP_INV    16'h0B01

`endif

// ---- design/sws_pkg.sv ----
package sws_pkg;

	// ==================== watchdog states, one-hot
	typedef enum logic [4:0] {
		ST_POR   = 5'b00001, // power-on hold, reset low
		ST_WAIT  = 5'b00010, // reset high, window closed
		ST_WIN   = 5'b00100, // trigger window open
		ST_FAULT = 5'b01000, // fault seen, reset pending
		ST_RST   = 5'b10000  // watchdog reset low phase
	} sws_state_t;

	// ==================== decoded commands
	typedef enum logic [2:0] {
		CMD_NONE     = 3'h0,
		CMD_TRIG_SET = 3'h1,
		CMD_TRIG_CLR = 3'h2,
		CMD_LAMP_DEF = 3'h3,
		CMD_LAMP_INV = 3'h4,
		CMD_MODE     = 3'h5,
		CMD_SOFT_RST = 3'h6
	} sws_cmd_t;

endpackage

// ---- design/sws_cmd_if.sv ----
`timescale 1ns/1ps
// ==================== latched command carrier
interface sws_cmd_if;
	logic        valid; // one-cycle pulse per good frame
	logic [15:0] word;  // holding latch contents
	modport src (output valid, output word);
	modport snk (input valid, input word);
endinterface

// ---- design/sws_spi_rx.sv ----
`timescale 1ns/1ps
`include "sws_map.svh"
module sws_spi_rx (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic ce_i,
	input  wire logic sclk_i,
	input  wire logic sdi_i,
	input  wire logic sel_low_i,
	sws_cmd_if.src    cmd
);
	// ==================== edge detection
	logic        sclk_d_r;  // previous shift clock level
	logic        sel_d_r;   // previous select level
	logic [15:0] shift_r;   // input shift register
	logic [15:0] latch_r;   // holding latch
	logic [4:0]  bits_r;    // clocks seen, saturates above 16
	logic        valid_r;   // latch pulse
	logic        sclk_rise;
	logic        sel_rise;

	assign sclk_rise = sclk_i & ~sclk_d_r;
	assign sel_rise  = sel_low_i & ~sel_d_r;

	// edge history
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sclk_d_r <= 1'b0;
			sel_d_r  <= 1'b1;
		end else if (ce_i) begin
			sclk_d_r <= sclk_i;
			sel_d_r  <= sel_low_i;
		end
	end

	// shift on every rising clock while selected
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			shift_r <= 16'h0000;
		end else if (ce_i && sclk_rise && !sel_low_i) begin
			shift_r <= {shift_r[14:0], sdi_i};
		end
	end

	// clock counter, saturating so a 17th edge spoils the frame
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			bits_r <= 5'h00;
		end else if (ce_i) begin
			if (sel_low_i) begin
				bits_r <= 5'h00;
			end else if (sclk_rise && bits_r != 5'h11) begin
				bits_r <= bits_r + 5'h01;
			end
		end
	end

	// transfer to latch only on exact frame length
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			latch_r <= 16'h0000;
			valid_r <= 1'b0;
		end else if (ce_i) begin
			valid_r <= 1'b0;
			if (sel_rise && bits_r == 5'(`SWS_FRAME_BITS)) begin
				latch_r <= shift_r;
				valid_r <= 1'b1;
			end
		end
	end

	assign cmd.valid = valid_r;
	assign cmd.word  = latch_r;
endmodule

// ---- testbench/sws_host.sv ----
`timescale 1ns/1ps
// ==================== host side serial master
module sws_host (
	input  wire logic clk_i,
	output logic      sclk_o,
	output logic      sdi_o,
	output logic      sel_low_o
);
	initial begin
		sclk_o    = 1'b0; // clock stands still between frames
		sdi_o     = 1'b0;
		sel_low_o = 1'b1;
	end

	// sends the top n bits of w, msb first; n below 16 makes a glitched frame
	task automatic send(input logic [15:0] w, input int n);
		int i;
		@(posedge clk_i);
		sel_low_o <= 1'b0;
		repeat (3) @(posedge clk_i);
		for (i = 15; i > 15 - n; i--) begin
			sdi_o <= w[i];
			repeat (3) @(posedge clk_i);
			sclk_o <= 1'b1;
			repeat (3) @(posedge clk_i);
			sclk_o <= 1'b0;
		end
		repeat (3) @(posedge clk_i);
		sel_low_o <= 1'b1;
		sdi_o     <= ~sdi_o; // released line shows no stale bit
		repeat (3) @(posedge clk_i);
	endtask
endmodule

// ---- testbench/sws_top_sva.sv ----
`timescale 1ns/1ps
module sws_top_sva #(
	parameter int OSC_CYCLES     = 4,
	parameter int WD_DIV_NORM    = 5,
	parameter int WD_DIV_FAST    = 2,
	parameter int SAFE_DELAY_OSC = 20
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic logic_supply_good_i,
	input wire logic test_select_pin_high_i,
	input wire logic lamp_polarity_strap_i,
	input wire logic lamp_enable_in_i,
	input wire logic firing_enable_in_i,
	input wire logic host_reset_low_out_o,
	input wire logic firing_enable_out_o,
	input wire logic firing_enable_oe_o,
	input wire logic firing_allowed_o,
	input wire logic warning_lamp_driver_o,
	input wire logic extended_mode_o,
	input wire logic trigger_window_o
);
	// ==================== run-length helpers
	localparam int TN = OSC_CYCLES * WD_DIV_NORM; // clocks per tick
	logic [15:0] good_r; // supply good in a row
	logic [15:0] low_r;  // supply low in a row
	logic [15:0] hi_r;   // reset output high in a row
	logic [15:0] win_r;  // window open in a row
	// saturating counters, so long runs never wrap to a false short one
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			good_r <= 16'h0000;
			low_r  <= 16'h0000;
			hi_r   <= 16'h0000;
			win_r  <= 16'h0000;
		end else begin
			good_r <= logic_supply_good_i ? good_r + 16'(good_r != 16'hFFFF) : 16'h0000;
			low_r  <= !logic_supply_good_i ? low_r + 16'(low_r != 16'hFFFF) : 16'h0000;
			hi_r   <= host_reset_low_out_o ? hi_r + 16'(hi_r != 16'hFFFF) : 16'h0000;
			win_r  <= trigger_window_o ? win_r + 16'(win_r != 16'hFFFF) : 16'h0000;
		end
	end

	// ==================== properties
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	AST_PD_RST: assert property (low_r >= 2010 |-> !host_reset_low_out_o)
		else $error("reset output high after long supply loss");
	AST_POR_HOLD: assert property ($rose(host_reset_low_out_o) && !test_select_pin_high_i
		|-> good_r >= 64 * TN) else $error("reset released before power-on hold");
	AST_WIN_OPEN: assert property ($rose(trigger_window_o) && !test_select_pin_high_i
		|-> hi_r >= 32 * TN - 2) else $error("window opened too early");
	AST_WIN_LEN: assert property (win_r <= 32 * TN + 2)
		else $error("window open too long");
	AST_FE_AND: assert property (firing_allowed_o |-> !firing_enable_oe_o && !firing_enable_out_o)
		else $error("firing allowed while pin pulled low");
	AST_FE_BLOCK: assert property ((!firing_enable_in_i)[*4] |-> !firing_allowed_o)
		else $error("external low did not block firing");
	AST_FE_RST: assert property ((!host_reset_low_out_o)[*2] |-> firing_enable_oe_o)
		else $error("firing enable active during reset");
	AST_WIN_RST: assert property ((!host_reset_low_out_o)[*2] |-> !trigger_window_o && !extended_mode_o)
		else $error("window or extended mode during reset");
	AST_TEST_A: assert property ((test_select_pin_high_i && lamp_polarity_strap_i
		&& logic_supply_good_i)[*5] |-> host_reset_low_out_o && !firing_enable_oe_o)
		else $error("test mode did not force outputs");
	AST_LAMP_DEF: assert property ((!lamp_enable_in_i && $stable(lamp_polarity_strap_i))[*5]
		|-> warning_lamp_driver_o == lamp_polarity_strap_i) else $error("lamp not at strap default");
endmodule

bind sws_top sws_top_sva #(
	.OSC_CYCLES(OSC_CYCLES), .WD_DIV_NORM(WD_DIV_NORM),
	.WD_DIV_FAST(WD_DIV_FAST), .SAFE_DELAY_OSC(SAFE_DELAY_OSC)
) u_sva (.clk_i(clk_i), .rst_i(rst_i), .logic_supply_good_i(logic_supply_good_i),
	.test_select_pin_high_i(test_select_pin_high_i), .lamp_polarity_strap_i(lamp_polarity_strap_i),
	.lamp_enable_in_i(lamp_enable_in_i), .firing_enable_in_i(firing_enable_in_i),
	.host_reset_low_out_o(host_reset_low_out_o), .firing_enable_out_o(firing_enable_out_o),
	.firing_enable_oe_o(firing_enable_oe_o), .firing_allowed_o(firing_allowed_o),
	.warning_lamp_driver_o(warning_lamp_driver_o), .extended_mode_o(extended_mode_o),
	.trigger_window_o(trigger_window_o));

// ---- testbench/sws_top_test.sv ----
`timescale 1ns/1ps
module sws_top_test;
	// ==================== signals
	localparam int TN = 20; // clocks per tick with the short parameters
	logic clk_i = 1'b0, rst_i = 1'b1, sup = 1'b1, tpin = 1'b0, strap = 1'b1;
	logic lamp_en = 1'b0, mode_pin = 1'b0, ext_low = 1'b0;
	logic ce = 1'b1, hv = 1'b1, tover = 1'b0; // enable, rail and over-level pins
	logic sclk, sdi, sel_low, hrst, fe_out, fe_oe, fe_ok, lamp, ext, win;
	wire  fe_wire = !fe_oe && !ext_low; // pulled-up open-drain wire
	int   err_total = 0, n_checks = 0, cyc = 0, t0;

	always #2.5 clk_i = ~clk_i;

	sws_top #(.OSC_CYCLES(4), .WD_DIV_NORM(5), .WD_DIV_FAST(2), .SAFE_DELAY_OSC(20)) uut (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .logic_supply_good_i(sup),
		.high_voltage_rail_ok_i(hv), .test_select_pin_high_i(tpin),
		.test_select_pin_over_i(tover), .lamp_polarity_strap_i(strap),
		.lamp_enable_in_i(lamp_en), .safing_input_hold_i(1'b0), .mode_pin_i(mode_pin),
		.serial_shift_clock_i(sclk), .serial_data_i(sdi), .select_low_in_i(sel_low),
		.firing_enable_in_i(fe_wire), .host_reset_low_out_o(hrst),
		.firing_enable_out_o(fe_out), .firing_enable_oe_o(fe_oe), .firing_allowed_o(fe_ok),
		.warning_lamp_driver_o(lamp), .extended_mode_o(ext), .trigger_window_o(win));

	sws_host host (.clk_i(clk_i), .sclk_o(sclk), .sdi_o(sdi), .sel_low_o(sel_low));

	// ==================== helpers
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic logic [15:0] inr(input int v, input int lo, input int hi);
		return {15'h0000, (v >= lo && v <= hi)};
	endfunction
	task step(input int n); // sample where outputs have settled
		repeat (n) @(negedge clk_i);
	endtask
	task cmd(input logic [15:0] w);
		host.send(w, 16);
		step(4);
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// hang guard, well above the expected run
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_total++;
			test_done;
		end
	end

	// ==================== tests
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		t0 = cyc;
		while (hrst !== 1'b1) step(1);
		chk(inr(cyc - t0, 64 * TN, 65 * TN + 8), 16'h0001);
		t0 = cyc;
		while (win !== 1'b1) step(1);
		chk(inr(cyc - t0, 32 * TN - 2, 33 * TN), 16'h0001);
		$display("test power-on done");
		// pulse held over eight ticks high (three ticks plus a frame), then low
		cmd(16'h0A01);
		step(3 * TN);
		cmd(16'h0A00);
		step(3 * TN);
		chk(fe_ok, 16'h0001);
		chk(win, 16'h0000);
		@(posedge clk_i) ext_low <= 1'b1;
		step(5);
		chk(fe_ok, 16'h0000);
		chk(fe_oe, 16'h0000);
		@(posedge clk_i) ext_low <= 1'b0;
		$display("test trigger done");
		@(posedge clk_i) lamp_en <= 1'b1;
		cmd(16'h0B01);
		chk(lamp, 16'h0000);
		host.send(16'hFFFF, 15); // would soft-reset the lamp if taken
		step(4);
		chk(lamp, 16'h0000);
		cmd(16'h0B00);
		chk(lamp, 16'h0001);
		@(posedge clk_i) ce <= 1'b0; // frozen receiver must miss this frame
		cmd(16'h0B01);
		@(posedge clk_i) ce <= 1'b1;
		step(2);
		chk(lamp, 16'h0001);
		cmd(16'h0B01);
		chk(lamp, 16'h0000);
		@(posedge clk_i) hv <= 1'b0; // rail loss drops back to strap default
		step(5);
		chk(lamp, 16'h0001);
		@(posedge clk_i) hv <= 1'b1;
		@(posedge clk_i) mode_pin <= 1'b1;
		step(4);
		cmd(16'h0B01);
		chk(lamp, 16'h0001);
		cmd(16'hFE00);
		chk(ext, 16'h0001);
		cmd(16'h0B01);
		chk(lamp, 16'h0000);
		cmd(16'hFFFF);
		chk(ext, 16'h0001);
		@(posedge clk_i) lamp_en <= 1'b0;
		strap <= 1'b0;
		step(6);
		chk(lamp, 16'h0000);
		$display("test lamp done");
		// no further trigger: the watchdog must bite
		while (fe_oe !== 1'b1) step(1);
		t0 = cyc;
		chk(fe_ok, 16'h0000);
		while (hrst !== 1'b0) step(1);
		chk(inr(cyc - t0, 63 * TN, 65 * TN), 16'h0001);
		step(2); // mode flag follows the reset pin by one register
		chk(ext, 16'h0000);
		t0 = cyc;
		while (hrst !== 1'b1) step(1);
		chk(inr(cyc - t0, 63 * TN, 65 * TN), 16'h0001);
		$display("test fault done");
		@(posedge clk_i) mode_pin <= 1'b0;
		strap <= 1'b1;
		sup   <= 1'b0;
		step(2100);
		chk(hrst, 16'h0000);
		chk(fe_oe, 16'h0001);
		@(posedge clk_i) sup <= 1'b1;
		tpin <= 1'b1;
		step(8);
		chk(hrst, 16'h0001);
		chk(fe_oe, 16'h0000);
		// mode c: still forced, but ticks every 8 clocks
		@(posedge clk_i) tover <= 1'b1;
		t0 = cyc;
		while (win !== 1'b1) step(1);
		chk(inr(cyc - t0, 90 * 8, 99 * 8), 16'h0001);
		chk(hrst, 16'h0001);
		@(posedge clk_i) tpin <= 1'b0;
		tover <= 1'b0;
		step(4);
		$display("test power-down done");
		test_done;
	end
endmodule
